// >>> hw/data_transfer_instr_exec.sv
`timescale 1ns/10ps
`include "xfer_cfg.svh"
module data_transfer_instr_exec
    import xfer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output dmem_req_type     dmem_req,
    input  wire logic [15:0] dmem_rdata,
    output io_req_type       io_req,
    input  wire logic [7:0]  io_rdata,
    output logic             prog_rd,
    output logic [15:0]      prog_addr,
    input  wire logic [15:0] prog_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic opcode_type op_of(input logic [15:0] word);
        op_of = opcode_type'(word[`OPC_MSB:`OPC_LSB]);
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = addr == `OFS_INSTR || addr == `OFS_WORK ||
                    addr == `OFS_FLAGS || addr == `OFS_TMODE ||
                    addr == `OFS_STATUS || addr == `OFS_COUNT;
    endfunction

    function automatic logic is_zero(input logic [7:0] value);
        is_zero = value == 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    state_type   state;
    state_type   next_state;
    logic [15:0] instr;
    logic [15:0] next_instr;
    logic [7:0]  work_register;
    logic [7:0]  next_work;
    flags_type   flags;
    flags_type   next_flags;
    logic [7:0]  timer_mode_reg;
    logic [7:0]  next_tmode;
    logic [15:0] pointer;
    logic [15:0] next_pointer;
    logic [15:0] count;
    logic        aw_held;
    logic        next_aw_held;
    logic [7:0]  aw_addr;
    logic [7:0]  next_aw_addr;
    logic        w_held;
    logic        next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        do_write;
    logic [31:0] lane_mask;
    logic        start;
    opcode_type  op;

    wide_counter counter_u (
        .clock  (clock),
        .srst   (srst),
        .enable (timer_mode_reg[`TMODE_RUN]),
        .count  (count)
    );

    ////////////////////////////////////////////////////////////////////////
    // register bus slave

    // a held channel refuses the next item until the write commits
    assign awready  = !aw_held;
    assign wready   = !w_held;
    assign arready  = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign lane_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                        {8{w_strb[1]}}, {8{w_strb[0]}}};
    // an instruction written while one is running is dropped
    assign start = do_write && aw_addr == `OFS_INSTR && state == ST_IDLE
                   && w_strb[1:0] != 2'h0;
    assign op = op_of(instr);

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_tmode   = timer_mode_reg;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr == `OFS_TMODE)
                next_tmode = (timer_mode_reg & ~lane_mask[7:0])
                             | (w_data[7:0] & lane_mask[7:0]);
        end
        else if (bvalid && bready)
            next_bvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (araddr)
                `OFS_INSTR:  next_rdata = {16'h0000, instr};
                `OFS_WORK:   next_rdata = {24'h000000, work_register};
                `OFS_FLAGS:  next_rdata = {28'h0000000, flags};
                `OFS_TMODE:  next_rdata = {24'h000000, timer_mode_reg};
                `OFS_STATUS: next_rdata = {31'h00000000, state != ST_IDLE};
                `OFS_COUNT:  next_rdata = {16'h0000, count};
                default:     next_rdata = 32'h00000000;
            endcase
        end
        else if (rvalid && rready)
            next_rvalid = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            aw_held        <= 1'b0;
            aw_addr        <= 8'h00;
            w_held         <= 1'b0;
            w_data         <= 32'h00000000;
            w_strb         <= 4'h0;
            bvalid         <= 1'b0;
            bresp          <= `RESP_OKAY;
            rvalid         <= 1'b0;
            rdata          <= 32'h00000000;
            rresp          <= `RESP_OKAY;
            timer_mode_reg <= `TMODE_RST;
        end
        else
        begin
            aw_held        <= next_aw_held;
            aw_addr        <= next_aw_addr;
            w_held         <= next_w_held;
            w_data         <= next_w_data;
            w_strb         <= next_w_strb;
            bvalid         <= next_bvalid;
            bresp          <= next_bresp;
            rvalid         <= next_rvalid;
            rdata          <= next_rdata;
            rresp          <= next_rresp;
            timer_mode_reg <= next_tmode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction execution

    // memories answer in the same cycle, so each access fits one state
    always_comb
    begin
        next_state   = state;
        next_instr   = instr;
        next_work    = work_register;
        next_flags   = flags;
        next_pointer = pointer;
        dmem_req     = '0;
        io_req       = '0;
        prog_rd      = 1'b0;
        prog_addr    = 16'h0000;
        unique case (state)
            ST_IDLE:
            begin
                if (start)
                begin
                    next_instr = w_data[15:0] & lane_mask[15:0];
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                next_state = ST_IDLE;
                dmem_req.addr = instr[`ARG_MSB:`ARG_LSB];
                io_req.addr   = instr[`ARG_MSB:`ARG_LSB];
                unique case (op)
                    OP_LOAD_IMM:  next_work = instr[`ARG_MSB:`ARG_LSB];
                    OP_STORE_MEM:
                    begin
                        dmem_req.wr    = 1'b1;
                        dmem_req.wdata = {8'h00, work_register};
                    end
                    OP_LOAD_MEM:
                    begin
                        dmem_req.rd = 1'b1;
                        next_work   = dmem_rdata[7:0];
                        next_flags.result_null = is_zero(dmem_rdata[7:0]);
                    end
                    OP_LOAD_IO:
                    begin
                        io_req.rd = 1'b1;
                        next_work = io_rdata;
                        next_flags.result_null = is_zero(io_rdata);
                    end
                    OP_STORE_IO:
                    begin
                        io_req.wr    = 1'b1;
                        io_req.wdata = work_register;
                    end
                    OP_TABLE_HIGH, OP_TABLE_LOW:
                    begin
                        dmem_req.rd   = 1'b1;
                        dmem_req.wide = 1'b1;
                        next_pointer  = dmem_rdata;
                        next_state    = ST_TABLE2;
                    end
                    OP_SNAPSHOT:
                    begin
                        dmem_req.wr    = 1'b1;
                        dmem_req.wide  = 1'b1;
                        dmem_req.wdata = count;
                    end
                endcase
            end
            ST_TABLE2:
            begin
                prog_rd    = 1'b1;
                prog_addr  = pointer;
                next_work  = (op == OP_TABLE_HIGH) ? prog_rdata[15:8]
                                                   : prog_rdata[7:0];
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state         <= ST_IDLE;
            instr         <= `INSTR_RST;
            work_register <= `WORK_RST;
            flags         <= `FLAGS_RST;
            pointer       <= 16'h0000;
        end
        else
        begin
            state         <= next_state;
            instr         <= next_instr;
            work_register <= next_work;
            flags         <= next_flags;
            pointer       <= next_pointer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    sequence exec_of(opcode_type code);
        state == ST_EXEC && op == code;
    endsequence
    sequence table_tail;
        state == ST_TABLE2 && prog_rd && prog_addr == pointer
            && pointer == $past(dmem_rdata);
    endsequence

    imm_load_a: assert property (
        exec_of(OP_LOAD_IMM) |=> work_register == $past(instr[7:0])
            && flags == $past(flags))
        else $error("immediate load wrong");
    mem_store_a: assert property (
        exec_of(OP_STORE_MEM) |-> dmem_req.wr && !dmem_req.wide
            && dmem_req.wdata[7:0] == work_register ##1 $stable(flags))
        else $error("memory store wrong");
    mem_load_zero_a: assert property (
        exec_of(OP_LOAD_MEM) |=> work_register == $past(dmem_rdata[7:0])
            && flags.result_null == ($past(dmem_rdata[7:0]) == 8'h00)
            && flags[3:1] == $past(flags[3:1]))
        else $error("memory load flag wrong");
    io_load_zero_a: assert property (
        exec_of(OP_LOAD_IO) |=> work_register == $past(io_rdata)
            && flags.result_null == ($past(io_rdata) == 8'h00)
            && flags[3:1] == $past(flags[3:1]))
        else $error("io load flag wrong");
    io_store_a: assert property (
        exec_of(OP_STORE_IO) |-> io_req.wr && io_req.wdata == work_register
            ##1 $stable(flags))
        else $error("io store wrong");
    table_high_a: assert property (
        exec_of(OP_TABLE_HIGH) |=> table_tail ##1 (state == ST_IDLE
            && work_register == $past(prog_rdata[15:8]) && $stable(flags)))
        else $error("high table read wrong");
    table_low_a: assert property (
        exec_of(OP_TABLE_LOW) |=> table_tail ##1 (state == ST_IDLE
            && work_register == $past(prog_rdata[7:0]) && $stable(flags)))
        else $error("low table read wrong");
    snapshot_a: assert property (
        exec_of(OP_SNAPSHOT) |-> dmem_req.wr && dmem_req.wide
            && dmem_req.wdata == count ##1 $stable(flags))
        else $error("snapshot wrong");
    single_cycle_a: assert property (
        state == ST_EXEC && op != OP_TABLE_HIGH && op != OP_TABLE_LOW
            |=> state == ST_IDLE)
        else $error("transfer overran one cycle");
    zero_exact_a: assert property (
        $changed(flags.result_null) |-> flags.result_null
            == (work_register == 8'h00))
        else $error("zero flag disagrees with value");
endmodule

// >>> hw/wide_counter.sv
`timescale 1ns/10ps
`include "xfer_cfg.svh"
module wide_counter
    import xfer_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        enable,
    output logic [15:0]      count
);
    logic [15:0] next_count;

    always_comb
    begin
        next_count = count;
        if (enable)
            next_count = count + 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            count <= `COUNT_RST;
        else
            count <= next_count;
    end

    // a stopped count must stand still so a snapshot sees it
    hold_when_off_a: assert property (
        @(posedge clock) disable iff (srst)
        !enable |=> count == $past(count))
        else $error("wide counter moved while stopped");

    step_when_on_a: assert property (
        @(posedge clock) disable iff (srst)
        enable |=> count == $past(count) + 16'h0001)
        else $error("wide counter did not step while running");
endmodule

// >>> hw/xfer_cfg.svh
`ifndef XFER_CFG_SVH
`define XFER_CFG_SVH

// register byte addresses
`define OFS_INSTR   8'h00
`define OFS_WORK    8'h04
`define OFS_FLAGS   8'h08
`define OFS_TMODE   8'h0C
`define OFS_STATUS  8'h10
`define OFS_COUNT   8'h14

// instruction word fields
`define OPC_MSB     10
`define OPC_LSB     8
`define ARG_MSB     7
`define ARG_LSB     0

// timer mode run bit and reset values
`define TMODE_RUN   5
`define TMODE_RST   8'h00
`define FLAGS_RST   4'h0
`define WORK_RST    8'h00
`define COUNT_RST   16'h0000
`define INSTR_RST   16'h0000

// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hw/xfer_pkg.sv
package xfer_pkg;
    typedef enum logic [2:0] {
        OP_LOAD_IMM, OP_STORE_MEM, OP_LOAD_MEM, OP_LOAD_IO,
        OP_STORE_IO, OP_TABLE_HIGH, OP_TABLE_LOW, OP_SNAPSHOT
    } opcode_type;

    typedef enum {ST_IDLE, ST_EXEC, ST_TABLE2} state_type;

    typedef struct packed {
        logic signed_range_flag;
        logic half_borrow_flag;
        logic borrow;
        logic result_null;
    } flags_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        wide;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } dmem_req_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_type;
endpackage

// >>> verification/test_data_transfer_instr_exec.sv
`timescale 1ns/10ps
`include "xfer_cfg.svh"
module test_data_transfer_instr_exec;
    import xfer_pkg::*;
    logic         clock = 1'b0;
    logic         srst = 1'b1;
    logic         awvalid = 1'b0;
    logic [7:0]   awaddr = 8'h00;
    logic         wvalid = 1'b0;
    logic [31:0]  wdata = 32'h0;
    logic [3:0]   wstrb = 4'h0;
    logic         bready = 1'b0;
    logic         arvalid = 1'b0;
    logic [7:0]   araddr = 8'h00;
    logic         rready = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, prog_rd;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    logic [15:0]  dmem_rdata, prog_addr, prog_rdata;
    logic [7:0]   io_rdata;
    logic [15:0]  prog_seen = 16'h0;
    dmem_req_type dmem_req;
    io_req_type   io_req;
    int           n_mismatch = 0;
    int           checked = 0;
    int           cyc = 0;
    int           n_strobe = 0;
    int           ptr_cyc = 0;
    int           prog_cyc = 0;

    data_transfer_instr_exec data_transfer_instr_exec_inst (
        .clock(clock), .srst(srst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .io_req(io_req),
        .io_rdata(io_rdata), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata));
    xfer_mem_model xfer_mem_model_inst (.clock(clock),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .io_req(io_req),
        .io_rdata(io_rdata), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata));

    always #50 clock = ~clock;

    // strobe cycles and the moments of the two table steps
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (dmem_req.rd | dmem_req.wr | io_req.rd | io_req.wr | prog_rd)
            n_strobe <= n_strobe + 1;
        if (dmem_req.rd & dmem_req.wide)
            ptr_cyc <= cyc;
        if (prog_rd)
            prog_cyc <= cyc;
        if (prog_rd)
            prog_seen <= prog_addr;
    end

    ////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic timeout(input string what);
        n_mismatch++;
        $display("wrong value %s expected answer seen none", what);
        finish_test();
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, released one by one when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        int   n;
        logic ta, tw, got;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        got = 1'b0;
        n = 0;
        r = 2'h3;
        // sample mid-cycle: handshake inputs are settled there
        while (!got && n < 80)
        begin
            @(negedge clock);
            ta = awvalid & awready;
            tw = wvalid & wready;
            got = bvalid & bready;
            r = bresp;
            @(posedge clock);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!got)
            timeout("write response");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int   n;
        logic ta, got;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        got = 1'b0;
        n = 0;
        while (!got && n < 80)
        begin
            @(negedge clock);
            ta = arvalid & arready;
            got = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (ta)
                arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!got)
            timeout("read data");
    endtask

    // one instruction, then wait for idle and count its strobe cycles
    task automatic exec(input opcode_type op, input logic [7:0] arg,
                        input int ns);
        logic [1:0]  r;
        logic [31:0] d;
        int          s0, k;
        s0 = n_strobe;
        axi_write(`OFS_INSTR, {21'h0, op, arg}, 4'hF, r);
        check("instr write resp", `RESP_OKAY, r);
        d = 32'h1;
        k = 0;
        while (d[0] !== 1'b0 && k < 20)
        begin
            axi_read(`OFS_STATUS, d, r);
            k++;
        end
        if (d[0] !== 1'b0)
            timeout("busy");
        check("strobe cycles", ns, n_strobe - s0);
        // the instruction register reads back what was issued
        axi_read(`OFS_INSTR, d, r);
        check("instr", {21'h0, op, arg}, d);
    endtask

    task automatic expect_acc(input logic [7:0] w, input logic [3:0] f);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(`OFS_WORK, d, r);
        check("work_register", w, d[7:0]);
        axi_read(`OFS_FLAGS, d, r);
        check("flags", f, d[3:0]);
    endtask

    ////////////////////////////////////////
    task automatic test_reset;
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(`OFS_TMODE, d, r);
        check("timer_mode_reg", `TMODE_RST, d[7:0]);
        check("mapped read resp", `RESP_OKAY, r);
        axi_read(`OFS_COUNT, d, r);
        check("count", `COUNT_RST, d[15:0]);
        expect_acc(`WORK_RST, `FLAGS_RST);
        axi_read(8'h18, d, r);
        check("unmapped read resp", `RESP_SLVERR, r);
        axi_write(8'h18, 32'hFF, 4'hF, r);
        check("unmapped write resp", `RESP_SLVERR, r);
        axi_write(`OFS_WORK, 32'h77, 4'hF, r);
        expect_acc(8'h00, 4'h0);
        $display("test_reset done");
    endtask

    task automatic test_mem;
        exec(OP_LOAD_MEM, 8'h20, 1);
        expect_acc(8'h00, 4'h1);
        exec(OP_LOAD_IMM, 8'h5A, 0);
        expect_acc(8'h5A, 4'h1);
        exec(OP_STORE_MEM, 8'h20, 1);
        check("data byte", 8'h5A, xfer_mem_model_inst.dmem[8'h20]);
        check("next byte", 8'h00, xfer_mem_model_inst.dmem[8'h21]);
        expect_acc(8'h5A, 4'h1);
        exec(OP_LOAD_MEM, 8'h20, 1);
        expect_acc(8'h5A, 4'h0);
        exec(OP_LOAD_IMM, 8'h00, 0);
        expect_acc(8'h00, 4'h0);
        $display("test_mem done");
    endtask

    task automatic test_io;
        exec(OP_LOAD_IMM, 8'hC3, 0);
        exec(OP_STORE_IO, 8'h31, 1);
        check("io byte", 8'hC3, xfer_mem_model_inst.iomem[8'h31]);
        expect_acc(8'hC3, 4'h0);
        exec(OP_LOAD_IO, 8'h40, 1);
        expect_acc(8'h00, 4'h1);
        exec(OP_STORE_IO, 8'h32, 1);
        expect_acc(8'h00, 4'h1);
        exec(OP_LOAD_IO, 8'h31, 1);
        expect_acc(8'hC3, 4'h0);
        $display("test_io done");
    endtask

    // table holds address xor 5AC3: 1234 gives 48F7
    task automatic test_table;
        exec(OP_LOAD_IMM, 8'h34, 0);
        exec(OP_STORE_MEM, 8'h50, 1);
        exec(OP_LOAD_IMM, 8'h12, 0);
        exec(OP_STORE_MEM, 8'h51, 1);
        exec(OP_LOAD_MEM, 8'h70, 1);
        exec(OP_TABLE_HIGH, 8'h50, 2);
        check("table gap", 1, prog_cyc - ptr_cyc);
        check("table address", 16'h1234, prog_seen);
        expect_acc(8'h48, 4'h1);
        exec(OP_TABLE_LOW, 8'h50, 2);
        check("table gap", 1, prog_cyc - ptr_cyc);
        expect_acc(8'hF7, 4'h1);
        $display("test_table done");
    endtask

    task automatic test_timer;
        logic [31:0] d, c1, c2;
        logic [1:0]  r;
        axi_write(`OFS_TMODE, 32'h20, 4'hF, r);
        axi_read(`OFS_TMODE, d, r);
        check("timer_mode_reg", 8'h20, d[7:0]);
        axi_read(`OFS_COUNT, c1, r);
        axi_read(`OFS_COUNT, c2, r);
        check("count moving", 1'b1, c2[15:0] !== c1[15:0]);
        axi_write(`OFS_TMODE, 32'h00, 4'hF, r);
        axi_read(`OFS_COUNT, c1, r);
        axi_read(`OFS_COUNT, c2, r);
        check("count held", c1[15:0], c2[15:0]);
        exec(OP_SNAPSHOT, 8'h60, 1);
        check("snapshot", c1[15:0], {xfer_mem_model_inst.dmem[8'h61],
              xfer_mem_model_inst.dmem[8'h60]});
        expect_acc(8'hF7, 4'h1);
        $display("test_timer done");
    endtask

    ////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        test_reset();
        test_mem();
        test_io();
        test_table();
        test_timer();
        finish_test();
    end
endmodule

// >>> verification/xfer_mem_model.sv
`timescale 1ns/10ps
module xfer_mem_model
    import xfer_pkg::*;
(
    input  wire logic         clock,
    input  wire dmem_req_type dmem_req,
    output logic [15:0]       dmem_rdata,
    input  wire io_req_type   io_req,
    output logic [7:0]        io_rdata,
    input  wire logic         prog_rd,
    input  wire logic [15:0]  prog_addr,
    output logic [15:0]       prog_rdata
);
    // both spaces start cleared so a zero byte is at hand
    logic [7:0]  dmem [256] = '{default: 8'h00};
    logic [7:0]  iomem [256] = '{default: 8'h00};
    logic [15:0] junk = 16'hA5C3;

    ////////////////////////////////////////

    // junk moves every cycle, so a read outside its strobe never matches
    always @(posedge clock)
        junk <= junk + 16'h3B5D;

    // all three spaces answer in the strobe cycle itself
    assign dmem_rdata = dmem_req.rd ?
        {dmem[dmem_req.addr + 8'h01], dmem[dmem_req.addr]} : junk;
    assign io_rdata = io_req.rd ? iomem[io_req.addr] : junk[7:0];
    // table contents are a fixed scramble of the address
    assign prog_rdata = prog_rd ? (prog_addr ^ 16'h5AC3) : junk;

    ////////////////////////////////////////
    // writes land at the edge that ends the strobe cycle
    always @(posedge clock)
    begin
        if (dmem_req.wr)
            dmem[dmem_req.addr] <= dmem_req.wdata[7:0];
        if (dmem_req.wr && dmem_req.wide)
            dmem[dmem_req.addr + 8'h01] <= dmem_req.wdata[15:8];
        if (io_req.wr)
            iomem[io_req.addr] <= io_req.wdata;
    end
endmodule
